//--- pio_map.vh
`ifndef PIO_MAP_VH
`define PIO_MAP_VH

// register addresses
`define PIO_ADDR_LAT0   8'h80
`define PIO_ADDR_LAT1   8'h90
`define PIO_ADDR_LAT2   8'ha0
`define PIO_ADDR_LAT3   8'hb0
`define PIO_ADDR_DRV0   8'ha4
`define PIO_ADDR_DRV1   8'ha5
`define PIO_ADDR_DRV2   8'ha6
`define PIO_ADDR_DRV3   8'ha7
`define PIO_ADDR_ADS1   8'had
`define PIO_ADDR_ADS2   8'hae
`define PIO_ADDR_RC2    8'he3
`define PIO_ADDR_RC3    8'he4

// page that holds the configuration registers
`define PIO_PAGE_CFG    8'h0f

// reset values
`define PIO_RST_LAT     8'hff
`define PIO_RST_DRV     8'h00
`define PIO_RST_ADS     8'hff
`define PIO_RST_RC      8'h00

// writable bits of the routing registers
`define PIO_RC2_WMASK   8'hdc
`define PIO_RC3_WMASK   8'h8f

// routing_control_two fields
`define PIO_RC2_PUOFF   7
`define PIO_RC2_ROUTE   6
`define PIO_RC2_T4CAP   4
`define PIO_RC2_T4CNT   3
`define PIO_RC2_UART2   2

// routing_control_three fields
`define PIO_RC3_CANPP   7
`define PIO_RC3_CMP2    3
`define PIO_RC3_CONV    2
`define PIO_RC3_T3CAP   1
`define PIO_RC3_T3CNT   0

`endif

//--- pio_pin.v
`timescale 1ns/1ns
`default_nettype none

module pio_pin (
  // clock and reset
  input  wire core_clk,
  input  wire nrst,
  // configuration
  input  wire latch_bit,
  input  wire push_pull,
  input  wire digital,
  input  wire route_on,
  input  wire pu_global_off,
  // peripheral override
  input  wire periph_sel,
  input  wire periph_val,
  input  wire periph_od,
  input  wire can_pin,
  input  wire can_pp,
  // pad
  input  wire pad_in,
  output reg  pad_out,
  output reg  pad_oe,
  output reg  pad_pu,
  // synchronised level for reads
  output wire level
);

  reg  sync1_q;
  reg  sync2_q;
  wire drv_val;
  wire drv_push;
  wire oe_d;

  // peripheral value wins only while the matrix is on
  assign drv_val  = (route_on & periph_sel) ? periph_val : latch_bit;
  // forced open-drain pins ignore the mode bit
  assign drv_push = (route_on & periph_sel & can_pin) ? can_pp :
                    (push_pull & ~(route_on & periph_sel & periph_od));
  // with the matrix on, low always driven, high only in push-pull; analog pins too
  assign oe_d = route_on & (~drv_val | drv_push);
  // analog pins read 0, digital pins read the pad
  assign level = digital & sync2_q;

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      pad_out <= 1'b1;
      pad_oe  <= 1'b0;
      pad_pu  <= 1'b1;
    end
    else
    begin
      sync1_q <= pad_in;
      sync2_q <= sync1_q;
      pad_out <= drv_val;
      pad_oe  <= oe_d;
      // pull-up off when globally off, analog, or driving low
      pad_pu  <= ~pu_global_off & digital & ~(oe_d & ~drv_val);
    end
  end

endmodule

`default_nettype wire

//--- pio_top.v
`timescale 1ns/1ns
`default_nettype none
`include "pio_map.vh"

module pio_top (
  // clock and reset
  input  wire        core_clk,
  input  wire        nrst,
  // byte register access
  input  wire [7:0]  sfr_addr,
  input  wire [7:0]  sfr_page,
  input  wire        sfr_wr,
  input  wire        sfr_rd,
  input  wire        sfr_rmw,
  input  wire [7:0]  sfr_wdata,
  output reg  [7:0]  sfr_rdata,
  output reg         sfr_hit,
  // bit access to the data registers
  input  wire [7:0]  bit_addr,
  input  wire        bit_wr,
  input  wire        bit_rd,
  input  wire        bit_wdata,
  output reg         bit_rdata,
  output reg         bit_hit,
  // per-pin assignment from the priority matrix
  input  wire [31:0] periph_sel,
  input  wire [31:0] periph_val,
  input  wire [31:0] periph_od,
  input  wire [31:0] can_tx_pin,
  // routing enables toward peripherals and the matrix
  output wire        route_matrix_on,
  output wire        pullup_global_off,
  output wire        tmr4_capture_in_route,
  output wire        tmr4_count_in_route,
  output wire        second_uart_route,
  output wire        can_tx_drive_select,
  output wire        cmp2_out_route,
  output wire        slow_conv_start_route,
  output wire        tmr3_capture_in_route,
  output wire        tmr3_count_in_route,
  output wire [7:0]  slow_conv_analog_in,
  // pads of ports 0 to 3
  input  wire [31:0] pin_in,
  output wire [31:0] pin_out,
  output wire [31:0] pin_oe,
  output wire [31:0] pin_pu
);

  // register state
  reg  [31:0] lat_q;
  reg  [31:0] lat_d;
  reg  [31:0] drv_q;
  reg  [31:0] drv_d;
  reg  [7:0]  ads1_q;
  reg  [7:0]  ads1_d;
  reg  [7:0]  ads2_q;
  reg  [7:0]  ads2_d;
  reg  [7:0]  rc2_q;
  reg  [7:0]  rc2_d;
  reg  [7:0]  rc3_q;
  reg  [7:0]  rc3_d;
  reg  [7:0]  skip_q;

  // decode
  reg  [3:0]  sel;
  reg         sel_ok;
  wire        cfg_page;
  wire [31:0] digital;
  wire [31:0] level;
  wire        bit_ok;
  wire [4:0]  bit_idx;
  reg  [7:0]  rd_byte;

  localparam [3:0] SEL_LAT0 = 4'h0;
  localparam [3:0] SEL_LAT1 = 4'h1;
  localparam [3:0] SEL_LAT2 = 4'h2;
  localparam [3:0] SEL_LAT3 = 4'h3;
  localparam [3:0] SEL_DRV0 = 4'h4;
  localparam [3:0] SEL_DRV1 = 4'h5;
  localparam [3:0] SEL_DRV2 = 4'h6;
  localparam [3:0] SEL_DRV3 = 4'h7;
  localparam [3:0] SEL_ADS1 = 4'h8;
  localparam [3:0] SEL_ADS2 = 4'h9;
  localparam [3:0] SEL_RC2  = 4'ha;
  localparam [3:0] SEL_RC3  = 4'hb;

  assign cfg_page = (sfr_page == `PIO_PAGE_CFG);

  // ports 0 and 3 have no analog mode
  assign digital = {8'hff, ads2_q, ads1_q, 8'hff};

  // bit addresses 0x80..0x87, 0x90..0x97, 0xa0..0xa7 and 0xb0..0xb7 map onto the four data registers
  assign bit_ok  = bit_addr[7] & ~bit_addr[6] & ~bit_addr[3];
  assign bit_idx = {bit_addr[5:4], bit_addr[2:0]};

  // field outputs straight from the routing registers
  assign pullup_global_off     = rc2_q[`PIO_RC2_PUOFF];
  assign route_matrix_on       = rc2_q[`PIO_RC2_ROUTE];
  assign tmr4_capture_in_route = rc2_q[`PIO_RC2_T4CAP];
  assign tmr4_count_in_route   = rc2_q[`PIO_RC2_T4CNT];
  assign second_uart_route     = rc2_q[`PIO_RC2_UART2];
  assign can_tx_drive_select   = rc3_q[`PIO_RC3_CANPP];
  assign cmp2_out_route        = rc3_q[`PIO_RC3_CMP2];
  assign slow_conv_start_route = rc3_q[`PIO_RC3_CONV];
  assign tmr3_capture_in_route = rc3_q[`PIO_RC3_T3CAP];
  assign tmr3_count_in_route   = rc3_q[`PIO_RC3_T3CNT];

  // analog port 1 pins are withheld from peripheral assignment
  assign slow_conv_analog_in = skip_q;

  // address decode: data registers on any page, the rest on page f only
  always @*
  begin
    sel    = SEL_LAT0;
    sel_ok = 1'b1;
    case (sfr_addr)
      `PIO_ADDR_LAT0: sel = SEL_LAT0;
      `PIO_ADDR_LAT1: sel = SEL_LAT1;
      `PIO_ADDR_LAT2: sel = SEL_LAT2;
      `PIO_ADDR_LAT3: sel = SEL_LAT3;
      `PIO_ADDR_DRV0:
      begin
        sel    = SEL_DRV0;
        sel_ok = cfg_page;
      end
      `PIO_ADDR_DRV1:
      begin
        sel    = SEL_DRV1;
        sel_ok = cfg_page;
      end
      `PIO_ADDR_DRV2:
      begin
        sel    = SEL_DRV2;
        sel_ok = cfg_page;
      end
      `PIO_ADDR_DRV3:
      begin
        sel    = SEL_DRV3;
        sel_ok = cfg_page;
      end
      `PIO_ADDR_ADS1:
      begin
        sel    = SEL_ADS1;
        sel_ok = cfg_page;
      end
      `PIO_ADDR_ADS2:
      begin
        sel    = SEL_ADS2;
        sel_ok = cfg_page;
      end
      `PIO_ADDR_RC2:
      begin
        sel    = SEL_RC2;
        sel_ok = cfg_page;
      end
      `PIO_ADDR_RC3:
      begin
        sel    = SEL_RC3;
        sel_ok = cfg_page;
      end
      default:
      begin
        sel    = SEL_LAT0;
        sel_ok = 1'b0;
      end
    endcase
  end

  // next register values from byte and bit writes
  always @*
  begin
    lat_d  = lat_q;
    drv_d  = drv_q;
    ads1_d = ads1_q;
    ads2_d = ads2_q;
    rc2_d  = rc2_q;
    rc3_d  = rc3_q;
    if (sfr_wr && sel_ok)
    begin
      case (sel)
        SEL_LAT0: lat_d[7:0]   = sfr_wdata;
        SEL_LAT1: lat_d[15:8]  = sfr_wdata;
        SEL_LAT2: lat_d[23:16] = sfr_wdata;
        SEL_LAT3: lat_d[31:24] = sfr_wdata;
        SEL_DRV0: drv_d[7:0]   = sfr_wdata;
        SEL_DRV1: drv_d[15:8]  = sfr_wdata;
        SEL_DRV2: drv_d[23:16] = sfr_wdata;
        SEL_DRV3: drv_d[31:24] = sfr_wdata;
        SEL_ADS1: ads1_d       = sfr_wdata;
        SEL_ADS2: ads2_d       = sfr_wdata;
        // unused and reserved bits are not stored
        SEL_RC2:  rc2_d = sfr_wdata & `PIO_RC2_WMASK;
        SEL_RC3:  rc3_d = sfr_wdata & `PIO_RC3_WMASK;
        default:  lat_d = lat_q;
      endcase
    end
    // a bit write in the same cycle lands after the byte write
    if (bit_wr && bit_ok)
    begin
      lat_d[bit_idx] = bit_wdata;
    end
  end

  // byte read source; rmw read phase sees the latch, else the pins
  always @*
  begin
    rd_byte = 8'h00;
    case (sel)
      SEL_LAT0: rd_byte = sfr_rmw ? lat_q[7:0]   : level[7:0];
      SEL_LAT1: rd_byte = sfr_rmw ? lat_q[15:8]  : level[15:8];
      SEL_LAT2: rd_byte = sfr_rmw ? lat_q[23:16] : level[23:16];
      SEL_LAT3: rd_byte = sfr_rmw ? lat_q[31:24] : level[31:24];
      SEL_DRV0: rd_byte = drv_q[7:0];
      SEL_DRV1: rd_byte = drv_q[15:8];
      SEL_DRV2: rd_byte = drv_q[23:16];
      SEL_DRV3: rd_byte = drv_q[31:24];
      SEL_ADS1: rd_byte = ads1_q;
      SEL_ADS2: rd_byte = ads2_q;
      SEL_RC2:  rd_byte = rc2_q;
      SEL_RC3:  rd_byte = rc3_q;
      default:  rd_byte = 8'h00;
    endcase
    if (!sel_ok)
    begin
      rd_byte = 8'h00;
    end
  end

  // registers
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      lat_q  <= {4{`PIO_RST_LAT}};
      drv_q  <= {4{`PIO_RST_DRV}};
      ads1_q <= `PIO_RST_ADS;
      ads2_q <= `PIO_RST_ADS;
      // matrix starts off, so pins start as inputs
      rc2_q  <= `PIO_RST_RC;
      rc3_q  <= `PIO_RST_RC;
    end
    else
    begin
      lat_q  <= lat_d;
      drv_q  <= drv_d;
      ads1_q <= ads1_d;
      ads2_q <= ads2_d;
      rc2_q  <= rc2_d;
      rc3_q  <= rc3_d;
    end
  end

  // read answers, one cycle after the strobe
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      sfr_rdata <= 8'h00;
      sfr_hit   <= 1'b0;
      bit_rdata <= 1'b0;
      bit_hit   <= 1'b0;
    end
    else
    begin
      sfr_hit <= (sfr_rd | sfr_wr) & sel_ok;
      if (sfr_rd)
      begin
        sfr_rdata <= rd_byte;
      end
      bit_hit <= (bit_rd | bit_wr) & bit_ok;
      if (bit_rd)
      begin
        // bit reads are rmw-style only when flagged
        bit_rdata <= bit_ok & (sfr_rmw ? lat_q[bit_idx] : level[bit_idx]);
      end
    end
  end

  // skip mask kept in a flop so the matrix never sees a glitch
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      skip_q <= 8'h00;
    end
    else
    begin
      skip_q <= ~ads1_d;
    end
  end

  // one pad cell per pin of ports 0 to 3
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1)
    begin : g_pin
      pio_pin u_pin (
        .core_clk      (core_clk),
        .nrst          (nrst),
        .latch_bit     (lat_q[g]),
        .push_pull     (drv_q[g]),
        .digital       (digital[g]),
        .route_on      (rc2_q[`PIO_RC2_ROUTE]),
        .pu_global_off (rc2_q[`PIO_RC2_PUOFF]),
        .periph_sel    (periph_sel[g]),
        .periph_val    (periph_val[g]),
        .periph_od     (periph_od[g]),
        .can_pin       (can_tx_pin[g]),
        .can_pp        (rc3_q[`PIO_RC3_CANPP]),
        .pad_in        (pin_in[g]),
        .pad_out       (pin_out[g]),
        .pad_oe        (pin_oe[g]),
        .pad_pu        (pin_pu[g]),
        .level         (level[g])
      );
    end
  endgenerate

endmodule

`default_nettype wire

//--- pio_props.sv
`timescale 1ns/1ns
`default_nettype none
module pio_props (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        nrst,
  // register access
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_page,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic        sfr_rmw,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        sfr_hit,
  input wire logic        bit_wr,
  // routing and pins
  input wire logic [31:0] periph_sel,
  input wire logic [31:0] periph_val,
  input wire logic [31:0] periph_od,
  input wire logic [31:0] can_tx_pin,
  input wire logic        route_matrix_on,
  input wire logic        pullup_global_off,
  input wire logic        can_tx_drive_select,
  input wire logic [7:0]  slow_conv_analog_in,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] pin_pu
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_lat0_wr;
    sfr_wr && !bit_wr && sfr_addr == 8'h80;
  endsequence
  sequence s_no_periph0;
    periph_sel[7:0] == 8'h00 && can_tx_pin[7:0] == 8'h00;
  endsequence
  property p_lat_drive;
    s_lat0_wr ##1 s_no_periph0 |=> pin_out[7:0] == $past(sfr_wdata, 2)
      && (pin_oe[7:0] & ~$past(sfr_wdata, 2))
         == ($past(route_matrix_on) ? ~$past(sfr_wdata, 2) : 8'h00);
  endproperty
  a_lat_drive: assert property (p_lat_drive) else $error("latch drive wrong");
  property p_rmw;
    sfr_rd && sfr_rmw && sfr_addr == 8'h80 && periph_sel[7:0] == 8'h00 |=> sfr_rdata == pin_out[7:0];
  endproperty
  a_rmw: assert property (p_rmw) else $error("rmw read not latch");
  property p_pu_off;
    pullup_global_off |=> pin_pu == 32'h0;
  endproperty
  a_pu_off: assert property (p_pu_off) else $error("pull-up left on");
  property p_no_fight;
    (pin_pu & pin_oe & ~pin_out) == 32'h0;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("pull-up on driven low");
  property p_matrix_off;
    !route_matrix_on |=> pin_oe == 32'h0;
  endproperty
  a_matrix_off: assert property (p_matrix_off) else $error("pin driven, matrix off");
  property p_rsvd;
    sfr_rd && sfr_page == 8'h0f && (sfr_addr == 8'he3 || sfr_addr == 8'he4)
      |=> (sfr_rdata & ($past(sfr_addr) == 8'he3 ? 8'h23 : 8'h70)) == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit reads one");
  property p_page;
    sfr_rd && sfr_page != 8'h0f && sfr_addr[7:4] == 4'he |=> !sfr_hit && sfr_rdata == 8'h00;
  endproperty
  a_page: assert property (p_page) else $error("config seen off page");
  property p_any_page;
    (sfr_rd || sfr_wr) && sfr_addr == 8'h80 |=> sfr_hit;
  endproperty
  a_any_page: assert property (p_any_page) else $error("data register missed");
  property p_analog_rd;
    sfr_rd && !sfr_rmw && sfr_addr == 8'h90 |=> (sfr_rdata & $past(slow_conv_analog_in)) == 8'h00;
  endproperty
  a_analog_rd: assert property (p_analog_rd) else $error("analog pin reads one");
  property p_od;
    route_matrix_on && periph_sel[16] && periph_od[16] && periph_val[16] && !can_tx_pin[16]
      |=> !pin_oe[16];
  endproperty
  a_od: assert property (p_od) else $error("open-drain pin drives high");
  property p_can;
    route_matrix_on && periph_sel[24] && can_tx_pin[24] && can_tx_drive_select
      |=> pin_oe[24];
  endproperty
  a_can: assert property (p_can) else $error("can push-pull not driven");
endmodule
bind pio_top pio_props u_props (.core_clk, .nrst, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd,
  .sfr_rmw, .sfr_wdata, .sfr_rdata, .sfr_hit, .bit_wr, .periph_sel, .periph_val, .periph_od,
  .can_tx_pin, .route_matrix_on, .pullup_global_off, .can_tx_drive_select,
  .slow_conv_analog_in, .pin_out, .pin_oe, .pin_pu);
`default_nettype wire

//--- pio_board.sv
`timescale 1ns/1ns
`default_nettype none
module pio_board (
  // device pads
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] pin_pu,
  // board drivers
  input  wire logic [31:0] ext_en,
  input  wire logic [31:0] ext_val,
  output logic      [31:0] pin_in
);
  // a floating pin with no pull-up shows the inverse of the pad value
  always_comb
    for (int i = 0; i < 32; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i]
                  : pin_pu[i] ? 1'b1 : ~pin_out[i];
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module testbench;
  logic        core_clk = 0;
  logic        nrst = 0;
  logic [7:0]  sfr_addr = 0, sfr_page = 0, sfr_wdata = 0, bit_addr = 0;
  logic        sfr_wr = 0, sfr_rd = 0, sfr_rmw = 0, bit_wr = 0, bit_rd = 0, bit_wdata = 0;
  logic [31:0] periph_sel = 0, periph_val = 0, periph_od = 0, can_tx_pin = 0;
  logic [31:0] ext_en = 0, ext_val = 0, pin_in, pin_out, pin_oe, pin_pu;
  logic [7:0]  sfr_rdata, slow_conv_analog_in, rv;
  logic        sfr_hit, bit_rdata, bit_hit, hv;
  logic        route_matrix_on, pullup_global_off, tmr4_capture_in_route, tmr4_count_in_route;
  logic        second_uart_route, can_tx_drive_select, cmp2_out_route, slow_conv_start_route;
  logic        tmr3_capture_in_route, tmr3_count_in_route;
  int          error_cnt = 0, tests_run = 0, cyc = 0;
  wire  [7:0]  rc2_o = {pullup_global_off, route_matrix_on, 1'b0, tmr4_capture_in_route,
                        tmr4_count_in_route, second_uart_route, 2'b00};
  wire  [7:0]  rc3_o = {can_tx_drive_select, 3'b000, cmp2_out_route, slow_conv_start_route,
                        tmr3_capture_in_route, tmr3_count_in_route};
  pio_top dut (.core_clk, .nrst, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd, .sfr_rmw, .sfr_wdata,
    .sfr_rdata, .sfr_hit, .bit_addr, .bit_wr, .bit_rd, .bit_wdata, .bit_rdata, .bit_hit,
    .periph_sel, .periph_val, .periph_od, .can_tx_pin, .route_matrix_on, .pullup_global_off,
    .tmr4_capture_in_route, .tmr4_count_in_route, .second_uart_route, .can_tx_drive_select,
    .cmp2_out_route, .slow_conv_start_route, .tmr3_capture_in_route, .tmr3_count_in_route,
    .slow_conv_analog_in, .pin_in, .pin_out, .pin_oe, .pin_pu);
  pio_board u_board (.pin_out, .pin_oe, .pin_pu, .ext_en, .ext_val, .pin_in);
  initial forever #5 core_clk = ~core_clk;
  task automatic print_verdict;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  // ends one edge past the second edge, so pin outputs have settled
  task automatic wr(input logic [7:0] a, d, p = 8'h0f);
    @(negedge core_clk);
    {sfr_addr, sfr_wdata, sfr_page, sfr_wr} = {a, d, p, 1'b1};
    @(negedge core_clk);
    sfr_wr = 0;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic m = 1'b0, input logic [7:0] p = 8'h0f);
    @(negedge core_clk);
    {sfr_addr, sfr_rmw, sfr_page, sfr_rd} = {a, m, p, 1'b1};
    @(negedge core_clk);
    {sfr_rd, sfr_rmw, rv, hv} = {2'b00, sfr_rdata, sfr_hit};
  endtask
  task automatic bacc(input logic [7:0] a, input logic w, d);
    @(negedge core_clk);
    {bit_addr, bit_wr, bit_rd, bit_wdata} = {a, w, ~w, d};
    @(negedge core_clk);
    {bit_wr, bit_rd, hv} = {2'b00, bit_hit};
  endtask
  task automatic t_reset;
    `CHK("oe", 32'h0, pin_oe)
    `CHK("pu", 32'hffffffff, pin_pu)
    `CHK("route", 16'h0, {rc2_o, rc3_o})
    `CHK("skip rst", 8'h00, slow_conv_analog_in)
    rd(8'ha4);
    `CHK("drv0", 8'h00, rv)
    rd(8'had);
    `CHK("ads1", 8'hff, rv)
    rd(8'h80);
    `CHK("pins0", 8'hff, rv)
  endtask
  task automatic t_page;
    wr(8'he3, 8'h40, 8'h00);
    `CHK("off page wr", 1'b0, route_matrix_on)
    rd(8'he3, 0, 8'h00);
    `CHK("off page rd", 9'h0, {hv, rv})
    rd(8'h80, 0, 8'h00);
    `CHK("any page", 1'b1, hv)
    rd(8'h81);
    `CHK("unmapped", 9'h0, {hv, rv})
  endtask
  task automatic t_rc;
    wr(8'he3, 8'hff);
    wr(8'he4, 8'hff);
    rd(8'he3);
    `CHK("rc2", 8'hdc, rv)
    rd(8'he4);
    `CHK("rc3", 8'h8f, rv)
    `CHK("route out", 16'hdc8f, {rc2_o, rc3_o})
    `CHK("pu off", 32'h0, pin_pu)
    wr(8'he3, 8'h00);
    wr(8'he4, 8'h00);
    `CHK("cleared", 16'h0, {rc2_o, rc3_o})
  endtask
  task automatic t_drive;
    wr(8'he3, 8'h40);
    wr(8'h80, 8'h0f);
    `CHK("oe out", 16'hf00f, {pin_oe[7:0], pin_out[7:0]})
    `CHK("pu low", 8'h0f, pin_pu[7:0])
    ext_en[0] = 1;
    repeat (2) @(negedge core_clk);
    rd(8'h80);
    `CHK("pin rd", 8'h0e, rv)
    rd(8'h80, 1);
    `CHK("rmw rd", 8'h0f, rv)
    ext_en[0] = 0;
    wr(8'ha4, 8'hff);
    `CHK("push", 8'hff, pin_oe[7:0])
  endtask
  // board pulls port 1 high so a leaking analog pin would read one
  task automatic t_analog;
    {ext_en[15:8], ext_val[15:8]} = 16'hffff;
    wr(8'had, 8'hf0);
    `CHK("skip", 8'h0f, slow_conv_analog_in)
    `CHK("pu1", 8'hf0, pin_pu[15:8])
    rd(8'h90);
    `CHK("analog rd", 8'hf0, rv)
    ext_en[15:8] = 8'h00;
    wr(8'ha5, 8'hff);
    `CHK("analog drive", 8'hff, pin_oe[15:8])
  endtask
  task automatic t_bits;
    bacc(8'h91, 1, 0);
    `CHK("bit hit", 1'b1, hv)
    rd(8'h90, 1, 8'h00);
    `CHK("bit latch", 8'hfd, rv)
    bacc(8'hb0, 0, 0);
    `CHK("bit rd", 2'b11, {hv, bit_rdata})
  endtask
  task automatic t_periph;
    wr(8'ha6, 8'hff);
    {periph_sel, periph_val, periph_od} = {32'h0101_0000, 32'h0101_0000, 32'h0001_0000};
    can_tx_pin = 32'h0100_0000;
    wr(8'he4, 8'h80);
    `CHK("od can pp", 2'b10, {pin_oe[24], pin_oe[16]})
    periph_od = 0;
    wr(8'he4, 8'h00);
    `CHK("pp can od", 2'b01, {pin_oe[24], pin_oe[16]})
    wr(8'he3, 8'h00);
    `CHK("matrix off", 32'h0, pin_oe)
  endtask
  // ports 2 and 3 registers, matrix off, board pulls port 2 high
  task automatic t_upper;
    {ext_en[23:16], ext_val[23:16]} = 16'hffff;
    wr(8'hae, 8'h3c);
    wr(8'hb0, 8'h5a);
    wr(8'ha7, 8'h81);
    wr(8'ha0, 8'h0f);
    `CHK("oe out2", 16'h000f, {pin_oe[23:16], pin_out[23:16]})
    `CHK("pu2", 8'h3c, pin_pu[23:16])
    rd(8'hae);
    `CHK("ads2", 8'h3c, rv)
    rd(8'ha7);
    `CHK("drv3", 8'h81, rv)
    rd(8'ha0);
    `CHK("analog rd2", 8'h3c, rv)
    rd(8'hb0, 1);
    `CHK("rmw rd3", 8'h5a, rv)
    @(negedge core_clk);
    sfr_rmw = 1;
    bacc(8'hb0, 0, 0);
    sfr_rmw = 0;
    `CHK("bit rmw", 2'b10, {hv, bit_rdata})
    ext_en[23:16] = 8'h00;
  endtask
  initial
  begin
    repeat (16) @(negedge core_clk);
    nrst = 1;
    t_reset();
    t_page();
    t_rc();
    t_drive();
    t_analog();
    t_bits();
    t_periph();
    t_upper();
    print_verdict();
  end
endmodule
`default_nettype wire
